// *** pkg/lpsc_pkg.sv ***
// Constants, register map and state types of the link power state control.
// Assumes one core clock at 250 MHz and a synchronous active-high reset.
package lpsc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
  localparam int TW = 36;
  typedef logic [TW-1:0] lpsc_cnt_t;

  localparam int L0S_DFLT_NS = 6900;
  localparam int L0S_DFLT_CYC = (L0S_DFLT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] L1A_DFLT_US = 16'h03E8;
  localparam logic [15:0] L1A_DFLT_MS = L1A_DFLT_US / 16'h03E8;
  localparam logic [15:0] GAP_DFLT_NS = 16'h251C;
  localparam logic [15:0] PSW_DFLT_US = 16'h0004;
  localparam logic [15:0] REARM_DFLT_US = 16'h0032;
  localparam logic [15:0] TOFF_DFLT_MS = 16'h000A;
  localparam logic [7:0] TOFF_NEVER = 8'hFF;

  // ****************************************
  // Register offsets and fields
  // ****************************************
  localparam logic [7:0] OFS_SIM = 8'h00;
  localparam logic [7:0] OFS_L0S = 8'h40;
  localparam logic [7:0] OFS_L1A = 8'h50;
  localparam logic [7:0] OFS_GAP = 8'h54;
  localparam logic [7:0] OFS_L1 = 8'h60;
  localparam logic [7:0] OFS_REARM = 8'h64;
  localparam logic [7:0] OFS_CLKREQ = 8'h68;
  localparam logic [7:0] OFS_L2 = 8'h70;
  localparam logic [7:0] OFS_ACK_EP = 8'h80;
  localparam logic [7:0] OFS_ACK_RP = 8'h84;
  localparam logic [7:0] OFS_STATUS = 8'h90;
  localparam int BIT_EN = 0;
  localparam int TIME_LSB = 16;

  // ****************************************
  // Reported state codes
  // ****************************************
  localparam logic [4:0] CODE_IDLE = 5'h00;
  localparam logic [4:0] CODE_L1_WAIT = 5'h01;
  localparam logic [4:0] CODE_L1 = 5'h05;
  localparam logic [4:0] CODE_L1_EXIT = 5'h0A;
  localparam logic [4:0] CODE_L2_WAIT = 5'h0B;
  localparam logic [4:0] CODE_L23 = 5'h0D;
  localparam logic [4:0] CODE_L2 = 5'h0F;
  localparam logic [4:0] CODE_L0S = 5'h10;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_L0S_WAIT = 9'h002,
    ST_L0S = 9'h004,
    ST_L1_WAIT = 9'h008,
    ST_L1 = 9'h010,
    ST_L1_EXIT = 9'h020,
    ST_L2_WAIT = 9'h040,
    ST_L23 = 9'h080,
    ST_L2 = 9'h100
  } lpsc_fsm_t;

  typedef struct packed {
    logic sim_fast;
    logic [15:0] l0s_time;
    logic l0s_en;
    logic [15:0] l1a_time;
    logic l1a_en;
    logic [13:0] gap_time;
    logic gap_dis;
    logic [15:0] psw_time;
    logic l1_en;
    logic [7:0] rearm_time;
    logic clkreq_drv;
    logic l2_en;
    logic ack_manual;
    logic [7:0] toff_thr;
  } lpsc_cfg_t;

  localparam lpsc_cfg_t CFG_RST = '{l0s_en: 1'b1, l1a_en: 1'b1, l1_en: 1'b1,
                                    l2_en: 1'b1, default: '0};

  typedef struct packed {
    lpsc_cfg_t cfg;
    lpsc_fsm_t st;
    logic [4:0] code;
    lpsc_cnt_t ent_cnt;
    lpsc_cnt_t gap_cnt;
    lpsc_cnt_t rearm_cnt;
    lpsc_cnt_t toff_cnt;
    logic toff_run;
    logic ack_pend;
    logic ack_in_q;
    logic ps_path;
    logic aspm_req;
    logic send_ack;
    logic l2_cont;
    logic block;
    logic clkreq_n;
    logic [31:0] rdata;
  } lpsc_state_t;

  localparam lpsc_state_t STATE_RST = '{cfg: CFG_RST, st: ST_IDLE, default: '0};

endpackage : lpsc_pkg

// *** src/lpsc_ctrl.sv ***
// Link power state control: timers, permissions and state report.
// Assumes all link-side inputs come from logic on the same core clock.
//
// How it works
// - Fast-timer bit turns millisecond timeouts into the same number of microseconds.
// - L0s entry waits programmed microseconds of idle; zero means 6.9 us.
// - L0s entered only while its permission bit is set; resets set.
// - ASPM L1 request waits programmed milliseconds; zero means 1000 us.
// - ASPM L1 entered only while its permission bit is set; resets set.
// - Consecutive ASPM L1 requests kept programmed ns apart; zero means 9500 ns.
// - Gap-disable bit set removes spacing between ASPM L1 requests; resets clear.
// - Upstream port waits programmed us after power-state write before L1; zero 4 us.
// - Non-ASPM L1 entered only while its permission bit is set; resets set.
// - After L1 exit outside D0, wait programmed us before non-ASPM L1 re-entry; zero 50 us.
// - Downstream port drives clock request only when drive bit set; resets clear.
// - L2 entered only while its permission bit is set; resets set.
// - Endpoint acknowledges turn-off automatically, or on user acknowledge rising edge.
// - Root waits programmed ms for acknowledge; 0xFF never times out, zero 10 ms.
// - State reported as 5-bit code with IDLE, L1, L23_READY, L2, L0s values.
module lpsc_ctrl #(
  parameter int P_CYC_PER_MS = 1000000 / lpsc_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Port role
  input wire logic i_is_downstream,
  input wire logic i_is_root,
  // Link events
  input wire logic i_link_idle,
  input wire logic i_ps_l1_req,
  input wire logic i_not_d0,
  input wire logic i_exit_req,
  input wire logic i_turn_off_rx,
  input wire logic i_turn_off_sent,
  input wire logic i_to_ack_rx,
  input wire logic i_l2_ready_ack,
  // Link controls
  output logic o_l0s,
  output logic o_aspm_l1_req,
  output logic o_block_tlps,
  output logic o_send_to_ack,
  output logic o_l2_continue,
  output logic o_clkreq_n,
  output logic o_clkreq_n_oe,
  output logic [4:0] o_pm_state
);

  lpsc_pkg::lpsc_state_t q;
  lpsc_pkg::lpsc_state_t n;
  logic ack_rise;
  logic gap_ok;

  // ****************************************
  // Delay conversion
  // ****************************************
  function automatic lpsc_pkg::lpsc_cnt_t us_cyc(input logic [15:0] v,
                                                 input logic [15:0] dflt);
    logic [15:0] u;
    u = (v == 16'h0000) ? dflt : v;
    return lpsc_pkg::lpsc_cnt_t'(u) * lpsc_pkg::lpsc_cnt_t'(lpsc_pkg::CYC_PER_US);
  endfunction : us_cyc

  function automatic lpsc_pkg::lpsc_cnt_t ms_cyc(input logic [15:0] v,
                                                 input logic [15:0] dflt,
                                                 input logic fast);
    logic [15:0] u;
    lpsc_pkg::lpsc_cnt_t unit;
    u = (v == 16'h0000) ? dflt : v;
    unit = fast ? lpsc_pkg::lpsc_cnt_t'(lpsc_pkg::CYC_PER_US)
                : lpsc_pkg::lpsc_cnt_t'(P_CYC_PER_MS);
    return lpsc_pkg::lpsc_cnt_t'(u) * unit;
  endfunction : ms_cyc

  function automatic lpsc_pkg::lpsc_cnt_t gap_cyc(input logic [13:0] v);
    lpsc_pkg::lpsc_cnt_t u;
    u = (v == 14'h0000) ? lpsc_pkg::lpsc_cnt_t'(lpsc_pkg::GAP_DFLT_NS)
                        : lpsc_pkg::lpsc_cnt_t'(v);
    // Round up so the spacing is never short
    return (u + lpsc_pkg::lpsc_cnt_t'(lpsc_pkg::CLK_PERIOD_NS - 1)) /
           lpsc_pkg::lpsc_cnt_t'(lpsc_pkg::CLK_PERIOD_NS);
  endfunction : gap_cyc

  function automatic logic [4:0] code_of(input lpsc_pkg::lpsc_fsm_t s);
    logic [4:0] c;
    c = lpsc_pkg::CODE_IDLE;
    case (s)
      lpsc_pkg::ST_L0S: c = lpsc_pkg::CODE_L0S;
      lpsc_pkg::ST_L1_WAIT: c = lpsc_pkg::CODE_L1_WAIT;
      lpsc_pkg::ST_L1: c = lpsc_pkg::CODE_L1;
      lpsc_pkg::ST_L1_EXIT: c = lpsc_pkg::CODE_L1_EXIT;
      lpsc_pkg::ST_L2_WAIT: c = lpsc_pkg::CODE_L2_WAIT;
      lpsc_pkg::ST_L23: c = lpsc_pkg::CODE_L23;
      lpsc_pkg::ST_L2: c = lpsc_pkg::CODE_L2;
      default: c = lpsc_pkg::CODE_IDLE;
    endcase
    return c;
  endfunction : code_of

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = q;
    n.aspm_req = 1'b0;
    n.send_ack = 1'b0;
    n.l2_cont = 1'b0;
    n.rdata = 32'h0000_0000;
    ack_rise = i_l2_ready_ack & ~q.ack_in_q;
    n.ack_in_q = i_l2_ready_ack;
    gap_ok = q.cfg.gap_dis || (q.gap_cnt == '0);

    // Register writes
    if (i_wr) begin
      if (i_addr == lpsc_pkg::OFS_SIM) begin
        n.cfg.sim_fast = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_L0S) begin
        n.cfg.l0s_time = i_wdata[lpsc_pkg::TIME_LSB +: 16];
        n.cfg.l0s_en = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_L1A) begin
        n.cfg.l1a_time = i_wdata[lpsc_pkg::TIME_LSB +: 16];
        n.cfg.l1a_en = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_GAP) begin
        n.cfg.gap_time = i_wdata[lpsc_pkg::TIME_LSB +: 14];
        n.cfg.gap_dis = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_L1) begin
        n.cfg.psw_time = i_wdata[lpsc_pkg::TIME_LSB +: 16];
        n.cfg.l1_en = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_REARM) begin
        n.cfg.rearm_time = i_wdata[lpsc_pkg::TIME_LSB +: 8];
      end else if (i_addr == lpsc_pkg::OFS_CLKREQ) begin
        n.cfg.clkreq_drv = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_L2) begin
        n.cfg.l2_en = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_ACK_EP) begin
        n.cfg.ack_manual = i_wdata[lpsc_pkg::BIT_EN];
      end else if (i_addr == lpsc_pkg::OFS_ACK_RP) begin
        n.cfg.toff_thr = i_wdata[7:0];
      end
    end

    // Register reads; unmapped offsets read zero
    if (i_rd) begin
      if (i_addr == lpsc_pkg::OFS_SIM) begin
        n.rdata = {31'h0, q.cfg.sim_fast};
      end else if (i_addr == lpsc_pkg::OFS_L0S) begin
        n.rdata = {q.cfg.l0s_time, 15'h0000, q.cfg.l0s_en};
      end else if (i_addr == lpsc_pkg::OFS_L1A) begin
        n.rdata = {q.cfg.l1a_time, 15'h0000, q.cfg.l1a_en};
      end else if (i_addr == lpsc_pkg::OFS_GAP) begin
        n.rdata = {2'h0, q.cfg.gap_time, 15'h0000, q.cfg.gap_dis};
      end else if (i_addr == lpsc_pkg::OFS_L1) begin
        n.rdata = {q.cfg.psw_time, 15'h0000, q.cfg.l1_en};
      end else if (i_addr == lpsc_pkg::OFS_REARM) begin
        n.rdata = {8'h00, q.cfg.rearm_time, 16'h0000};
      end else if (i_addr == lpsc_pkg::OFS_CLKREQ) begin
        n.rdata = {31'h0, q.cfg.clkreq_drv};
      end else if (i_addr == lpsc_pkg::OFS_L2) begin
        n.rdata = {31'h0, q.cfg.l2_en};
      end else if (i_addr == lpsc_pkg::OFS_ACK_EP) begin
        n.rdata = {31'h0, q.cfg.ack_manual};
      end else if (i_addr == lpsc_pkg::OFS_ACK_RP) begin
        n.rdata = {24'h000000, q.cfg.toff_thr};
      end else if (i_addr == lpsc_pkg::OFS_STATUS) begin
        n.rdata = {27'h0, q.code};
      end
    end

    // Free-running guard timers
    if (q.gap_cnt != '0) begin
      n.gap_cnt = q.gap_cnt - lpsc_pkg::lpsc_cnt_t'(1);
    end
    if (q.rearm_cnt != '0) begin
      n.rearm_cnt = q.rearm_cnt - lpsc_pkg::lpsc_cnt_t'(1);
    end

    // Endpoint acknowledge scheduling; a new turn-off beats a pending clear
    if (!i_is_root && i_turn_off_rx) begin
      if (!q.cfg.ack_manual) begin
        n.send_ack = 1'b1;
      end else begin
        n.ack_pend = 1'b1;
      end
    end else if (q.ack_pend && q.cfg.ack_manual && ack_rise) begin
      n.send_ack = 1'b1;
      n.ack_pend = 1'b0;
    end

    // Root acknowledge timeout
    if (i_is_root && i_turn_off_sent) begin
      n.toff_run = 1'b1;
      n.toff_cnt = ms_cyc({8'h00, q.cfg.toff_thr}, lpsc_pkg::TOFF_DFLT_MS, q.cfg.sim_fast);
    end else if (q.toff_run) begin
      if (i_to_ack_rx ||
          (q.cfg.toff_thr != lpsc_pkg::TOFF_NEVER && q.toff_cnt <= 1)) begin
        n.toff_run = 1'b0;
        n.l2_cont = 1'b1;
      end else if (q.cfg.toff_thr != lpsc_pkg::TOFF_NEVER) begin
        n.toff_cnt = q.toff_cnt - lpsc_pkg::lpsc_cnt_t'(1);
      end
    end

    // Power state machine
    case (q.st)
      lpsc_pkg::ST_IDLE: begin
        if (((!i_is_root && i_turn_off_rx) || (i_is_root && i_turn_off_sent)) &&
            q.cfg.l2_en) begin
          n.st = lpsc_pkg::ST_L2_WAIT;
        end else if (i_ps_l1_req && q.cfg.l1_en && q.rearm_cnt == '0) begin
          n.st = lpsc_pkg::ST_L1_WAIT;
          n.ps_path = 1'b1;
          // Downstream ports send no completion, so no wait
          n.ent_cnt = i_is_downstream ? lpsc_pkg::lpsc_cnt_t'(1)
                                      : us_cyc(q.cfg.psw_time, lpsc_pkg::PSW_DFLT_US);
        end else if (i_link_idle && q.cfg.l1a_en && gap_ok) begin
          n.st = lpsc_pkg::ST_L1_WAIT;
          n.ps_path = 1'b0;
          n.ent_cnt = ms_cyc(q.cfg.l1a_time, lpsc_pkg::L1A_DFLT_MS, q.cfg.sim_fast);
        end else if (i_link_idle && q.cfg.l0s_en) begin
          n.st = lpsc_pkg::ST_L0S_WAIT;
          n.ent_cnt = (q.cfg.l0s_time == 16'h0000)
                      ? lpsc_pkg::lpsc_cnt_t'(lpsc_pkg::L0S_DFLT_CYC)
                      : us_cyc(q.cfg.l0s_time, 16'h0001);
        end
      end
      lpsc_pkg::ST_L0S_WAIT: begin
        if (!i_link_idle || !q.cfg.l0s_en) begin
          n.st = lpsc_pkg::ST_IDLE;
        end else if (q.ent_cnt <= 1) begin
          n.st = lpsc_pkg::ST_L0S;
        end else begin
          n.ent_cnt = q.ent_cnt - lpsc_pkg::lpsc_cnt_t'(1);
        end
      end
      lpsc_pkg::ST_L0S: begin
        if (!i_link_idle) begin
          n.st = lpsc_pkg::ST_IDLE;
        end
      end
      lpsc_pkg::ST_L1_WAIT: begin
        if ((q.ps_path && !q.cfg.l1_en) ||
            (!q.ps_path && (!i_link_idle || !q.cfg.l1a_en))) begin
          n.st = lpsc_pkg::ST_IDLE;
        end else if (q.ent_cnt <= 1) begin
          n.st = lpsc_pkg::ST_L1;
          n.block = 1'b1;
          if (!q.ps_path) begin
            n.aspm_req = 1'b1;
            n.gap_cnt = q.cfg.gap_dis ? '0 : gap_cyc(q.cfg.gap_time);
          end
        end else begin
          n.ent_cnt = q.ent_cnt - lpsc_pkg::lpsc_cnt_t'(1);
        end
      end
      lpsc_pkg::ST_L1: begin
        if (i_exit_req) begin
          n.st = lpsc_pkg::ST_L1_EXIT;
        end
      end
      lpsc_pkg::ST_L1_EXIT: begin
        n.st = lpsc_pkg::ST_IDLE;
        n.block = 1'b0;
        if (i_not_d0) begin
          n.rearm_cnt = us_cyc({8'h00, q.cfg.rearm_time}, lpsc_pkg::REARM_DFLT_US);
        end
      end
      lpsc_pkg::ST_L2_WAIT: begin
        if (!q.cfg.l2_en) begin
          n.st = lpsc_pkg::ST_IDLE;
        end else if (q.send_ack || q.l2_cont) begin
          n.st = lpsc_pkg::ST_L23;
          n.block = 1'b1;
        end
      end
      lpsc_pkg::ST_L23: begin
        if (i_link_idle) begin
          n.st = lpsc_pkg::ST_L2;
        end
      end
      lpsc_pkg::ST_L2: begin
        if (i_exit_req) begin
          n.st = lpsc_pkg::ST_IDLE;
          n.block = 1'b0;
        end
      end
      default: begin
        n.st = lpsc_pkg::ST_IDLE;
      end
    endcase

    n.code = code_of(n.st);
    // Clock request released only where the reference clock may stop
    n.clkreq_n = (n.st == lpsc_pkg::ST_L1) || (n.st == lpsc_pkg::ST_L2);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= lpsc_pkg::STATE_RST;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rdata = q.rdata;
  assign o_l0s = (q.code == lpsc_pkg::CODE_L0S);
  assign o_aspm_l1_req = q.aspm_req;
  assign o_block_tlps = q.block;
  assign o_send_to_ack = q.send_ack;
  assign o_l2_continue = q.l2_cont;
  assign o_clkreq_n = q.clkreq_n;
  assign o_clkreq_n_oe = i_is_downstream & q.cfg.clkreq_drv;
  assign o_pm_state = q.code;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  lpsc_pkg::lpsc_cnt_t wait_cyc;
  always_ff @(posedge i_clk) begin
    if (i_reset || q.st != n.st) begin
      wait_cyc <= lpsc_pkg::lpsc_cnt_t'(1);
    end else begin
      wait_cyc <= wait_cyc + lpsc_pkg::lpsc_cnt_t'(1);
    end
  end

  chk_l0s_permit: assert property ($rose(o_l0s) |-> $past(q.cfg.l0s_en))
    else $error("L0s entered while not permitted");
  chk_l0s_wait: assert property (q.st == lpsc_pkg::ST_L0S_WAIT && n.st == lpsc_pkg::ST_L0S
    && q.cfg.l0s_time == 16'h0000 |-> wait_cyc >= lpsc_pkg::L0S_DFLT_CYC)
    else $error("L0s entered before default idle time");
  chk_aspm_permit: assert property (o_aspm_l1_req |-> $past(q.cfg.l1a_en))
    else $error("ASPM L1 requested while not permitted");
  chk_l1_permit: assert property ($rose(q.st == lpsc_pkg::ST_L1) && q.ps_path
    |-> $past(q.cfg.l1_en))
    else $error("L1 entry continued while not permitted");
  chk_l2_permit: assert property ($rose(q.st == lpsc_pkg::ST_L23) |-> $past(q.cfg.l2_en))
    else $error("L2 entry while not permitted");
  chk_gap_hold: assert property (o_aspm_l1_req && !q.cfg.gap_dis
    |-> q.gap_cnt == gap_cyc(q.cfg.gap_time))
    else $error("Minimum gap not armed after ASPM L1 request");
  chk_gap_block: assert property (q.st == lpsc_pkg::ST_IDLE && q.gap_cnt != '0 &&
    !q.cfg.gap_dis && !i_ps_l1_req |=> q.st != lpsc_pkg::ST_L1_WAIT)
    else $error("ASPM L1 started inside minimum gap");
  chk_clkreq_drive: assert property (o_clkreq_n_oe |-> q.cfg.clkreq_drv && i_is_downstream)
    else $error("Clock request driven without permission");
  chk_auto_ack: assert property (!i_is_root && i_turn_off_rx && !q.cfg.ack_manual
    |=> o_send_to_ack)
    else $error("Automatic acknowledge not scheduled");
  chk_manual_ack: assert property (o_send_to_ack && $past(q.cfg.ack_manual)
    |-> $past(i_turn_off_rx) == 1'b0 && $past(ack_rise))
    else $error("Manual acknowledge without user edge");
  chk_state_code: assert property (q.st == lpsc_pkg::ST_L1 |-> o_pm_state == 5'h05)
    else $error("L1 state code wrong");

  cov_l0s: cover property ($rose(o_l0s));
  cov_aspm_l1: cover property (o_aspm_l1_req);
  cov_l2: cover property ($rose(q.st == lpsc_pkg::ST_L2));
  cov_manual_ack: cover property (o_send_to_ack && q.cfg.ack_manual);

endmodule : lpsc_ctrl

// *** tb/lpsc_link_partner.sv ***
// Link partner model: turn-off messages toward an endpoint, acks toward a root.
// Assumes the bench pulses i_send_off and i_off_seen for one cycle each.
module lpsc_link_partner (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Bench commands
  input wire logic i_send_off,
  input wire logic i_off_seen,
  input wire logic i_ack_en,
  // Messages toward the device
  output logic o_turn_off_rx,
  output logic o_to_ack_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Ack comes 20 cycles late, so the root really waits
  always @(posedge i_clk) begin
    o_turn_off_rx <= i_send_off & ~i_reset;
    o_to_ack_rx <= (cnt == 1);
    if (i_reset) begin
      cnt <= 0;
    end else if (i_off_seen && i_ack_en) begin
      cnt <= 20;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : lpsc_link_partner

// *** tb/lpsc_ctrl_bench.sv ***
// Bench of the link power state control, one task per scenario.
// Assumes P_CYC_PER_MS of 1000, so one millisecond lasts 1000 cycles.
module lpsc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, dsp = 0, root = 0, idle = 0, psr = 0;
  logic nd0 = 0, ex = 0, sent = 0, uack = 0, soff = 0, acken = 0, torx, ackrx;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic l0s, l1r, blk, sack, cont, ckn, ckoe;
  logic [4:0] pst;
  int err_count = 0, check_count = 0, cyc = 0, n;

  lpsc_ctrl #(.P_CYC_PER_MS(1000)) uut (
    .i_clk(clk), .i_reset(rst), .i_addr(adr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_is_downstream(dsp), .i_is_root(root), .i_link_idle(idle),
    .i_ps_l1_req(psr), .i_not_d0(nd0), .i_exit_req(ex), .i_turn_off_rx(torx),
    .i_turn_off_sent(sent), .i_to_ack_rx(ackrx), .i_l2_ready_ack(uack), .o_l0s(l0s),
    .o_aspm_l1_req(l1r), .o_block_tlps(blk), .o_send_to_ack(sack),
    .o_l2_continue(cont), .o_clkreq_n(ckn), .o_clkreq_n_oe(ckoe), .o_pm_state(pst));
  lpsc_link_partner partner (.i_clk(clk), .i_reset(rst), .i_send_off(soff),
    .i_off_seen(sent), .i_ack_en(acken), .o_turn_off_rx(torx), .o_to_ack_rx(ackrx));

  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, input int hi);
    check_count++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask : rng

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask : rreg

  // Bits: 4 l0s, 3 aspm req, 2 block, 1 ack, 0 continue; n = lim if never seen
  task automatic wait_hi(input int b, input int lim);
    logic [4:0] m;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
      m = {l0s, l1r, blk, sack, cont};
    end while (m[b] !== 1'b1 && n < lim);
  endtask : wait_hi

  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) ex <= 1'b1;
    if (k == 1) soff <= 1'b1;
    if (k == 2) sent <= 1'b1;
    @(posedge clk);
    {ex, soff, sent} <= 3'h0;
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [7:0] a [12] = '{8'h00, 8'h40, 8'h50, 8'h54, 8'h60, 8'h64, 8'h68, 8'h70,
                           8'h80, 8'h84, 8'h90, 8'h20};
    // Enables at 0x40, 0x50, 0x60, 0x70 come out of reset set
    logic [11:0] en = 12'h096;
    wreg(8'h20, 32'hFFFFFFFF);
    wreg(8'h90, 32'h0000001F);
    foreach (a[i]) begin
      rreg(a[i], {31'h0, en[i]}, "reset value");
    end
    @(posedge clk) dsp <= 1'b1;
    #1 chk("clkreq oe", 32'h0, {31'h0, ckoe});
    chk("clkreq level", 32'h0, {31'h0, ckn});
    wreg(8'h68, 32'h1);
    #1 chk("clkreq oe", 32'h1, {31'h0, ckoe});
    wreg(8'h68, 32'h0);
    #1 chk("clkreq oe", 32'h0, {31'h0, ckoe});
    @(posedge clk) dsp <= 1'b0;
  endtask : t_regs

  task automatic t_l0s();
    wreg(8'h50, 32'h0);
    wreg(8'h40, 32'h0001_0000);
    @(posedge clk) idle <= 1'b1;
    wait_hi(4, 400);
    rng("l0s while off", 400, 400);
    wreg(8'h40, 32'h0001_0001);
    wait_hi(4, 400);
    rng("l0s delay", 249, 253);
    rreg(8'h90, 32'h10, "state code");
    wreg(8'h40, 32'h1);
    @(posedge clk) idle <= 1'b0;
    @(posedge clk) idle <= 1'b1;
    wait_hi(4, 2000);
    rng("l0s default", 1723, 1729);
    wreg(8'h40, 32'h0);
    @(posedge clk) idle <= 1'b0;
  endtask : t_l0s

  task automatic t_aspm();
    wreg(8'h50, 32'h0001_0001);
    @(posedge clk) idle <= 1'b1;
    wait_hi(3, 1100);
    rng("aspm delay", 998, 1003);
    pulse(0);
    wait_hi(3, 4000);
    rng("aspm gap", 3360, 3390);
    wreg(8'h54, 32'h1);
    wreg(8'h50, 32'h1);
    pulse(0);
    wait_hi(3, 1100);
    rng("aspm no gap", 996, 1006);
    wreg(8'h00, 32'h1);
    pulse(0);
    wait_hi(3, 400);
    rng("aspm fast", 246, 256);
    wreg(8'h50, 32'h0);
    wreg(8'h54, 32'h0);
    pulse(0);
    @(posedge clk) idle <= 1'b0;
  endtask : t_aspm

  task automatic t_psl1();
    wreg(8'h60, 32'h0001_0000);
    @(posedge clk) psr <= 1'b1;
    wait_hi(2, 300);
    rng("l1 while off", 300, 300);
    wreg(8'h60, 32'h0001_0001);
    wait_hi(2, 400);
    rng("upstream wait", 249, 254);
    wreg(8'h64, 32'h0002_0000);
    @(posedge clk) nd0 <= 1'b1;
    pulse(0);
    wait_hi(2, 1000);
    rng("l1 rearm", 740, 760);
    @(posedge clk) psr <= 1'b0;
    nd0 <= 1'b0;
    pulse(0);
  endtask : t_psl1

  task automatic t_ep();
    wreg(8'h70, 32'h0);
    pulse(1);
    wait_hi(2, 30);
    rng("block with l2 off", 30, 30);
    wreg(8'h70, 32'h1);
    pulse(1);
    wait_hi(1, 30);
    rng("auto ack", 0, 3);
    rreg(8'h90, 32'h0D, "state code");
    @(posedge clk) idle <= 1'b1;
    rreg(8'h90, 32'h0F, "state code");
    chk("state pin", 32'h0F, {27'h0, pst});
    chk("clkreq level", 32'h1, {31'h0, ckn});
    pulse(0);
    wreg(8'h80, 32'h1);
    pulse(1);
    wait_hi(1, 30);
    rng("ack before user", 30, 30);
    @(posedge clk) uack <= 1'b1;
    wait_hi(1, 10);
    rng("manual ack", 1, 3);
    uack <= 1'b0;
    // Let L23_READY settle into L2 before asking to leave
    repeat (2) @(posedge clk);
    pulse(0);
    @(posedge clk) idle <= 1'b0;
  endtask : t_ep

  task automatic t_root();
    wreg(8'h84, 32'h1);
    @(posedge clk) root <= 1'b1;
    pulse(2);
    wait_hi(0, 400);
    rng("turn-off timeout", 246, 254);
    wreg(8'h84, 32'hFF);
    pulse(2);
    wait_hi(0, 600);
    rng("timeout disabled", 600, 600);
    wreg(8'h70, 32'h0);
    wreg(8'h70, 32'h1);
    @(posedge clk) acken <= 1'b1;
    pulse(2);
    wait_hi(0, 100);
    rng("ack received", 17, 25);
  endtask : t_root

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_l0s();
    t_aspm();
    t_psl1();
    t_ep();
    t_root();
    report_and_stop();
  end
endmodule : lpsc_ctrl_bench
